// File: rtl/adcsq_pkg.sv
// package: register map, field layout, timing and types of the converter sequencer
package adcsq_pkg;
	// register byte addresses on apb
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_SEL    = 8'h04;
	localparam logic [7:0] OFS_RES_LO = 8'h08;
	localparam logic [7:0] OFS_RES_HI = 8'h0C;
	localparam logic [7:0] OFS_STAT   = 8'h10;
	localparam logic [7:0] OFS_CLR    = 8'h14;
	localparam logic [7:0] OFS_IEN    = 8'h18;
	localparam logic [7:0] OFS_SLEEP  = 8'h1C;
	localparam logic [7:0] OFS_PRESC  = 8'h20;
	// control register bit positions
	localparam int CTRL_EN_BIT    = 0;
	localparam int CTRL_START_BIT = 1;
	localparam int CTRL_FREE_BIT  = 2;
	// status / clear / enable layout
	localparam int EV_DONE_BIT = 0;
	localparam int EV_WAKE_BIT = 1;
	localparam int EV_WIDTH    = 2;
	// sleep command codes written to the sleep register
	localparam logic [1:0] SLP_NONE  = 2'h0;
	localparam logic [1:0] SLP_IDLE  = 2'h1;
	localparam logic [1:0] SLP_NOISE = 2'h2;
	localparam logic [1:0] SLP_DEEP  = 2'h3;
	// reset values
	localparam logic [7:0] SEL_RESET   = 8'h00;
	localparam logic [7:0] PRESC_RESET = 8'h01;
	// conversion lengths in converter clocks
	localparam int CONV_NORMAL_CLKS = 13;
	localparam int CONV_FIRST_CLKS  = 25;
	// result coding limits
	localparam logic [9:0] CODE_MAX_SE = 10'h3FF;
	localparam logic [9:0] CODE_MIN_DF = 10'h200;
	localparam logic [9:0] CODE_MAX_DF = 10'h1FF;
	// channel/gain codes from this up to DIFF_LAST are differential (below the fixed inputs)
	localparam logic [4:0] DIFF_FIRST = 5'h08;
	localparam logic [4:0] DIFF_LAST  = 5'h1D;

	// analog front-end request
	typedef struct packed {
		logic [1:0] ref_sel;
		logic [4:0] chan_sel;
		logic       sample;
		logic       busy;
	} adcsq_afe_type;

	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT_EDGE,
		ST_CONVERT
	} adcsq_state_type;
endpackage

// File: rtl/adcsq_top.sv
// converter sequencing, sleep conversion and result coding behind an apb slave
`timescale 1ns/100ps
module adcsq_top
	import adcsq_pkg::*;
#(
	parameter int PRESC_W = 8
)
(
	input  wire logic              CLOCK,
	input  wire logic              RST,
	input  wire logic              PSEL,
	input  wire logic              PENABLE,
	input  wire logic              PWRITE,
	input  wire logic [7:0]        PADDR,
	input  wire logic [31:0]       PWDATA,
	output logic                   PREADY,
	output logic [31:0]            PRDATA,
	output logic                   PSLVERR,
	input  wire logic              CPU_HALTED,
	input  wire logic              WAKE_EVENT,
	input  wire logic signed [11:0] AFE_CODE,
	output adcsq_afe_type          AFE_REQ,
	output logic                   CPU_SLEEP,
	output logic                   IRQ
);
	// refuse prescaler widths the compare cannot serve
	if (PRESC_W < 1 || PRESC_W > 8)
	begin : g_bad_presc
		$error("adcsq_top: PRESC_W must be 1..8");
	end

	// software-visible and internal sequencer state
	logic                 en_r, en_nxt;             // converter enable
	logic                 start_r, start_nxt;       // conversion start bit
	logic                 free_r, free_nxt;         // free-running mode
	logic [7:0]           sel_r, sel_nxt;           // buffered input select register
	logic [6:0]           lock_r, lock_nxt;         // selection seen by the front end
	logic [9:0]           res_r, res_nxt;           // last completed result
	logic [EV_WIDTH-1:0]  stat_r, stat_nxt;         // sticky events
	logic [EV_WIDTH-1:0]  ien_r, ien_nxt;           // interrupt enables
	logic [PRESC_W-1:0]   pdiv_r, pdiv_nxt;         // prescaler divide value
	logic [PRESC_W-1:0]   pcnt_r, pcnt_nxt;         // prescaler counter
	logic                 first_r, first_nxt;       // next conversion is the long one
	logic [4:0]           cyc_r, cyc_nxt;           // converter clocks left
	logic                 sleep_r, sleep_nxt;       // processor held asleep
	logic                 slpconv_r, slpconv_nxt;   // conversion owed to sleep entry
	logic [31:0]          rdata_r, rdata_nxt;       // read data register
	logic                 ready_r, ready_nxt;       // access phase answer
	logic                 err_r, err_nxt;           // answer to unmapped address or to write of result/status
	logic                 irq_r, irq_nxt;           // interrupt line
	logic                 samp_r, samp_nxt;         // sample strobe to front end
	adcsq_state_type      st_r, st_nxt;             // sequencer state
	logic                 busy_r, busy_nxt;         // conversion in progress, to front end
	logic                 cdiff_r, cdiff_nxt;       // sampled channel is a differential pair

	logic       wr, rd, tick;                       // bus strobes, converter clock tick
	logic [9:0] coded;                              // coded result of front-end value

	assign wr   = PSEL && PENABLE && PWRITE && !ready_r;
	assign rd   = PSEL && PENABLE && !PWRITE && !ready_r;
	assign tick = en_r && (pcnt_r == 0);

	// result coding from the front end's signed raw value
	always_comb
	begin
		if (cdiff_r)
		begin
			// two's complement with its sign in the top bit
			if (AFE_CODE > 12'sd511)
				coded = CODE_MAX_DF;
			else if (AFE_CODE < -12'sd512)
				coded = CODE_MIN_DF;
			else
				coded = AFE_CODE[9:0];
		end
		else
		begin
			// unsigned, ground at zero, saturating above reference
			if (AFE_CODE < 12'sd0)
				coded = 10'h000;
			else if (AFE_CODE > 12'sd1023)
				coded = CODE_MAX_SE;
			else
				coded = AFE_CODE[9:0];
		end
	end

	// next-state logic for bus, sequencer, sleep and interrupt
	always_comb
	begin
		en_nxt      = en_r;
		start_nxt   = start_r;
		free_nxt    = free_r;
		sel_nxt     = sel_r;
		lock_nxt    = lock_r;
		res_nxt     = res_r;
		stat_nxt    = stat_r;
		ien_nxt     = ien_r;
		pdiv_nxt    = pdiv_r;
		first_nxt   = first_r;
		cyc_nxt     = cyc_r;
		sleep_nxt   = sleep_r;
		slpconv_nxt = slpconv_r;
		st_nxt      = st_r;
		cdiff_nxt   = cdiff_r;
		samp_nxt    = 1'b0;
		rdata_nxt   = 32'h0000_0000;
		ready_nxt   = 1'b0;
		err_nxt     = 1'b0;
		// prescaler runs only while enabled, held at zero otherwise
		if (!en_r || pcnt_r >= pdiv_r)
			pcnt_nxt = '0;
		else
			pcnt_nxt = pcnt_r + 1'b1;

		// register writes
		if (wr)
		begin
			ready_nxt = 1'b1;
			case (PADDR)
				OFS_CTRL:
				begin
					en_nxt   = PWDATA[CTRL_EN_BIT];
					free_nxt = PWDATA[CTRL_FREE_BIT];
					if (PWDATA[CTRL_START_BIT])
						start_nxt = 1'b1;
					// enabling arms the long first conversion
					if (PWDATA[CTRL_EN_BIT] && !en_r)
						first_nxt = 1'b1;
				end
				OFS_SEL:   sel_nxt  = PWDATA[7:0];
				OFS_CLR:   stat_nxt = stat_r & ~PWDATA[EV_WIDTH-1:0];
				OFS_IEN:   ien_nxt  = PWDATA[EV_WIDTH-1:0];
				OFS_PRESC: pdiv_nxt = PWDATA[PRESC_W-1:0];
				OFS_SLEEP:
				begin
					// noise/idle sleep with preconditions arms a conversion
					if ((PWDATA[1:0] == SLP_IDLE || PWDATA[1:0] == SLP_NOISE)
						&& en_r && !start_r && !free_r && ien_r[EV_DONE_BIT])
						slpconv_nxt = 1'b1;
					// any other sleep state leaves enable alone
					sleep_nxt = (PWDATA[1:0] != SLP_NONE);
				end
				default:   err_nxt  = 1'b1;
			endcase
		end
		else if (rd)
		begin
			ready_nxt = 1'b1;
			case (PADDR)
				OFS_CTRL:   rdata_nxt = {29'h0, free_r, start_r, en_r};
				OFS_SEL:    rdata_nxt = {24'h0, sel_r};
				OFS_RES_LO: rdata_nxt = {24'h0, res_r[7:0]};
				OFS_RES_HI: rdata_nxt = {30'h0, res_r[9:8]};
				OFS_STAT:   rdata_nxt = {{(32-EV_WIDTH){1'b0}}, stat_r};
				OFS_IEN:    rdata_nxt = {{(32-EV_WIDTH){1'b0}}, ien_r};
				OFS_SLEEP:  rdata_nxt = {31'h0, sleep_r};
				OFS_PRESC:  rdata_nxt = {{(32-PRESC_W){1'b0}}, pdiv_r};
				OFS_CLR:    rdata_nxt = 32'h0000_0000;
				default:    err_nxt   = 1'b1;
			endcase
		end

		// a wake event ends sleep; staying awake until the next command
		if (sleep_r && WAKE_EVENT)
		begin
			sleep_nxt = 1'b0;
			stat_nxt[EV_WAKE_BIT] = 1'b1;
		end
		// sleep conversion begins once the processor has stopped
		if (slpconv_r && CPU_HALTED && st_r == ST_IDLE)
		begin
			start_nxt   = 1'b1;
			slpconv_nxt = 1'b0;
		end

		// selection follows the buffer while not converting
		if (st_r != ST_CONVERT)
			lock_nxt = {sel_r[7:6], sel_r[4:0]};

		// conversion sequencer
		case (st_r)
			ST_IDLE:
				if (en_r && start_nxt)
					st_nxt = ST_WAIT_EDGE;
			ST_WAIT_EDGE:
				// start on the next converter clock edge
				if (tick)
				begin
					cyc_nxt   = first_r ? 5'(CONV_FIRST_CLKS - 1) : 5'(CONV_NORMAL_CLKS - 1);
					first_nxt = 1'b0;
					samp_nxt  = 1'b1;
					st_nxt    = ST_CONVERT;
				end
			ST_CONVERT:
				if (tick)
				begin
					// reopen selection in the last clock before completion
					if (cyc_r == 5'd1)
						lock_nxt = {sel_r[7:6], sel_r[4:0]};
					if (cyc_r == 5'd0)
					begin
						// completion: result and flag together, start cleared only when not free-running
						res_nxt = coded;
						stat_nxt[EV_DONE_BIT] = 1'b1;
						if (free_r)
						begin
							// free-run restarts on the lock just reloaded
							cyc_nxt  = 5'(CONV_NORMAL_CLKS - 1);
							samp_nxt = 1'b1;
						end
						else
						begin
							start_nxt = 1'b0;
							st_nxt    = ST_IDLE;
						end
					end
					else
						cyc_nxt = cyc_r - 1'b1;
				end
			default: st_nxt = ST_IDLE;
		endcase

		// disabling terminates any conversion
		if (!en_nxt)
		begin
			st_nxt    = ST_IDLE;
			start_nxt = 1'b0;
		end
		// coding follows the channel that was sampled, not the lock reopened since
		if (samp_nxt)
			cdiff_nxt = (lock_nxt[4:0] >= DIFF_FIRST) && (lock_nxt[4:0] <= DIFF_LAST);
		busy_nxt = (st_nxt == ST_CONVERT);
		irq_nxt = |(stat_nxt & ien_nxt);
	end

	// register all state
	always_ff @(posedge CLOCK or posedge RST)
	begin
		if (RST)
		begin
			en_r      <= 1'b0;
			start_r   <= 1'b0;
			free_r    <= 1'b0;
			sel_r     <= SEL_RESET;
			lock_r    <= 7'h00;
			res_r     <= 10'h000;
			stat_r    <= '0;
			ien_r     <= '0;
			pdiv_r    <= PRESC_W'(PRESC_RESET);
			pcnt_r    <= '0;
			first_r   <= 1'b1;
			cyc_r     <= 5'd0;
			sleep_r   <= 1'b0;
			slpconv_r <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			ready_r   <= 1'b0;
			err_r     <= 1'b0;
			irq_r     <= 1'b0;
			samp_r    <= 1'b0;
			st_r      <= ST_IDLE;
			busy_r    <= 1'b0;
			cdiff_r   <= 1'b0;
		end
		else
		begin
			en_r      <= en_nxt;
			start_r   <= start_nxt;
			free_r    <= free_nxt;
			sel_r     <= sel_nxt;
			lock_r    <= lock_nxt;
			res_r     <= res_nxt;
			stat_r    <= stat_nxt;
			ien_r     <= ien_nxt;
			pdiv_r    <= pdiv_nxt;
			pcnt_r    <= pcnt_nxt;
			first_r   <= first_nxt;
			cyc_r     <= cyc_nxt;
			sleep_r   <= sleep_nxt;
			slpconv_r <= slpconv_nxt;
			rdata_r   <= rdata_nxt;
			ready_r   <= ready_nxt;
			err_r     <= err_nxt;
			irq_r     <= irq_nxt;
			samp_r    <= samp_nxt;
			st_r      <= st_nxt;
			busy_r    <= busy_nxt;
			cdiff_r   <= cdiff_nxt;
		end
	end

	// outputs straight from flip-flops
	assign PREADY            = ready_r;
	assign PRDATA            = rdata_r;
	assign PSLVERR           = err_r;
	assign IRQ               = irq_r;
	assign CPU_SLEEP         = sleep_r;
	assign AFE_REQ           = '{ref_sel: lock_r[6:5], chan_sel: lock_r[4:0],
	                             sample: samp_r, busy: busy_r};
endmodule

// File: testbench/adcsq_afe_model.sv
// model: analog front end holding the sampled level for the converter
`timescale 1ns/100ps
module adcsq_afe_model
	import adcsq_pkg::*;
(
	input  wire logic               CLOCK,
	input  wire adcsq_afe_type      REQ,
	input  wire logic signed [11:0] LEVEL,
	output logic signed [11:0]      CODE
);
	logic signed [11:0] held_r; // level on the hold capacitor
	// catch the level at each sampling pulse, held until the next one
	always_ff @(posedge CLOCK)
		if (REQ.sample)
			held_r <= LEVEL;
	// outside a conversion the held value is gone: show its inverse
	assign CODE = REQ.busy ? held_r : ~held_r;
endmodule

// File: testbench/adcsq_properties.sv
// checker: port-level properties of the converter sequencer
`timescale 1ns/100ps
module adcsq_properties
	import adcsq_pkg::*;
(
	input wire logic          CLOCK,
	input wire logic          RST,
	input wire logic          PSEL,
	input wire logic          PENABLE,
	input wire logic          PREADY,
	input wire logic [31:0]   PRDATA,
	input wire logic          PSLVERR,
	input wire logic          WAKE_EVENT,
	input wire logic          CPU_SLEEP,
	input wire adcsq_afe_type AFE_REQ
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RST);
	ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held too long");
	ready_answer_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("no answer");
	setup_quiet_a: assert property (PSEL && !PENABLE |-> !PREADY) else $error("ready in setup");
	rdata_idle_a: assert property (!PREADY |-> PRDATA == 32'h0) else $error("data outside answer");
	err_ready_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
	err_data_a: assert property (PSLVERR |-> PRDATA == 32'h0) else $error("data on refusal");
	sample_pulse_a: assert property (AFE_REQ.sample |=> !AFE_REQ.sample) else $error("long sample");
	busy_len_a: assert property ($rose(AFE_REQ.busy) |-> AFE_REQ.busy[*8])
		else $error("conversion too short");
	wake_leave_a: assert property (CPU_SLEEP && WAKE_EVENT |-> ##[1:4] !CPU_SLEEP)
		else $error("no wake");
endmodule
bind adcsq_top adcsq_properties chk (.*);

// File: testbench/testbench.sv
// testbench: random and corner conversions, refusal, sleep conversion
`timescale 1ns/100ps
module testbench;
	import adcsq_pkg::*;
	logic CLOCK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, CPU_HALTED = 0, WAKE_EVENT = 0;
	logic [7:0] PADDR = 8'h00, lo;
	logic [31:0] PWDATA = 32'h0, PRDATA, q, seed = 32'h82480741;
	logic PREADY, PSLVERR, CPU_SLEEP, IRQ, e;
	logic signed [11:0] AFE_CODE, level = 12'sh000;
	adcsq_afe_type AFE_REQ;
	int n_mismatch = 0, n_tests = 0, i;
	int blen = 0, blast = 0, nlen = CONV_FIRST_CLKS; // busy run, last run, expected run
	always #12.5 CLOCK = ~CLOCK;
	// length of each busy run in clocks, for the conversion-time checks
	always @(posedge CLOCK)
		if (AFE_REQ.busy === 1'b1)
			blen <= blen + 1;
		else if (blen != 0)
		begin
			blast <= blen;
			blen <= 0;
		end
	adcsq_top DUT (.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR),
		.CPU_HALTED(CPU_HALTED), .WAKE_EVENT(WAKE_EVENT), .AFE_CODE(AFE_CODE),
		.AFE_REQ(AFE_REQ), .CPU_SLEEP(CPU_SLEEP), .IRQ(IRQ));
	adcsq_afe_model AFE (.CLOCK(CLOCK), .REQ(AFE_REQ), .LEVEL(level), .CODE(AFE_CODE));
	// closing report
	task print_verdict;
		if (n_mismatch == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// one comparison
	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_tests++;
		if (g !== x)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, x, g);
		end
	endtask
	// one apb transfer, held until ready is sampled
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge CLOCK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CLOCK);
		PENABLE <= 1'b1;
		k = 0;
		do
		begin
			@(posedge CLOCK);
			k++;
		end
		while (PREADY !== 1'b1 && k < 20);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		if (k >= 20)
		begin
			n_mismatch++;
			print_verdict;
		end
	endtask
	// poll the done flag, bounded
	task wait_done;
		int k;
		k = 0;
		do
		begin
			bus(1'b0, OFS_STAT, 32'h0);
			k++;
		end
		while (q[EV_DONE_BIT] !== 1'b1 && k < 200);
		if (k >= 200)
		begin
			n_mismatch++;
			print_verdict;
		end
	endtask
	// expected result code for a channel and raw level
	function logic [9:0] exp_code(input logic [4:0] c, input logic signed [11:0] r);
		if (c >= DIFF_FIRST && c <= DIFF_LAST)
			return (r > 12'sh1FF) ? CODE_MAX_DF : (r < 12'shE00) ? CODE_MIN_DF : r[9:0];
		return (r > 12'sh3FF) ? CODE_MAX_SE : (r < 12'sh000) ? 10'h000 : r[9:0];
	endfunction
	function logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// check result bytes against the level
	task res(input logic [4:0] c, input logic signed [11:0] r);
		bus(1'b0, OFS_RES_LO, 32'h0);
		lo = q[7:0];
		bus(1'b0, OFS_RES_HI, 32'h0);
		chk("result", {22'h0, exp_code(c, r)}, {22'h0, q[1:0], lo});
	endtask
	// single conversion with full checking
	task conv(input logic [4:0] c, input logic signed [11:0] r);
		level <= r;
		bus(1'b1, OFS_SEL, {27'h0, c});
		bus(1'b1, OFS_CTRL, 32'h3);
		wait_done;
		chk("length", nlen, blast);
		nlen = CONV_NORMAL_CLKS;
		chk("irq", 32'h1, {31'h0, IRQ});
		bus(1'b0, OFS_CTRL, 32'h0);
		chk("start", 32'h0, {31'h0, q[CTRL_START_BIT]});
		res(c, r);
		bus(1'b1, OFS_CLR, 32'h1);
		bus(1'b0, OFS_STAT, 32'h0);
		chk("cleared", 32'h0, {31'h0, q[EV_DONE_BIT]});
		chk("irq off", 32'h0, {31'h0, IRQ});
	endtask
	initial
	begin
		repeat (2) @(posedge CLOCK);
		RST <= 1'b0;
		bus(1'b1, OFS_PRESC, 32'h0);
		bus(1'b1, OFS_IEN, 32'h1);
		conv(5'h03, 12'sh7FF);
		conv(5'h10, 12'sh258);
		conv(5'h08, 12'shDA8);
		for (i = 0; i < 6; i++)
		begin
			seed = xs(seed);
			conv(seed[4:0], seed[27:16]);
		end
		bus(1'b0, 8'hFC, 32'h0);
		chk("refused", 32'h1, {31'h0, e});
		chk("refused data", 32'h0, q);
		// free-running: a selection change after the first result shows in the one after next
		bus(1'b1, OFS_PRESC, 32'h3);
		level <= 12'shF00;
		bus(1'b1, OFS_SEL, 32'h3);
		bus(1'b1, OFS_CTRL, 32'h7);
		wait_done;
		bus(1'b1, OFS_CLR, 32'h1);
		bus(1'b1, OFS_SEL, 32'h10);
		wait_done;
		res(5'h03, 12'shF00);
		bus(1'b1, OFS_CLR, 32'h1);
		wait_done;
		res(5'h10, 12'shF00);
		// stop free-running, re-enable for a long first conversion, reselect only then
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b1, OFS_CLR, 32'h1);
		bus(1'b1, OFS_PRESC, 32'h0);
		bus(1'b1, OFS_CTRL, 32'h1);
		bus(1'b1, OFS_SEL, 32'h3);
		bus(1'b1, OFS_SLEEP, {30'h0, SLP_NOISE});
		level <= 12'sh155;
		CPU_HALTED <= 1'b1;
		repeat (3) @(posedge CLOCK);
		WAKE_EVENT <= 1'b1;
		@(posedge CLOCK);
		WAKE_EVENT <= 1'b0;
		CPU_HALTED <= 1'b0;
		wait_done;
		chk("sleep length", 32'(CONV_FIRST_CLKS), blast);
		chk("awake", 32'h0, {31'h0, CPU_SLEEP});
		res(5'h03, 12'sh155);
		bus(1'b1, OFS_SLEEP, {30'h0, SLP_DEEP});
		bus(1'b0, OFS_CTRL, 32'h0);
		chk("enable kept", 32'h1, {31'h0, q[CTRL_EN_BIT]});
		print_verdict;
	end
endmodule
